// ### hdl/rap_pkg.sv
// Shared constants and types for the relay, alarm and pulse output block.
// Assumes a 10 MHz clock and a plain register port with read data one cycle later.
package rap_pkg;

  // Timing
  localparam int CLK_HZ      = 10_000_000;
  localparam int TICK_MS     = 10;
  localparam int TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
  localparam int TICKS_PER_S = 1000 / TICK_MS;
  localparam int HOLD_S      = 5;
  localparam int HOLD_TICKS  = HOLD_S * TICKS_PER_S;

  // Fixed-point spans: 0x0400 is unity; rate and speed products shifted right by ten, pulse product by eight
  localparam logic [15:0] SPAN_UNITY  = 16'h0400;
  localparam int          SPAN_SHIFT  = 10;
  localparam int          HFR_SHIFT   = 8;

  // Register offsets (word index on the register port)
  localparam logic [5:0] ADDR_CTRL       = 6'h00;
  localparam logic [5:0] ADDR_RATE_SPAN  = 6'h01;
  localparam logic [5:0] ADDR_SPEED_SPAN = 6'h02;
  localparam logic [5:0] ADDR_HFR_SPAN   = 6'h03;
  localparam logic [5:0] ADDR_RATE_DISP  = 6'h04;
  localparam logic [5:0] ADDR_SPEED_DISP = 6'h05;
  localparam logic [5:0] ADDR_RELAY_ST   = 6'h06;
  localparam logic [1:0] RELAY_PAGE      = 2'h1;
  localparam logic [2:0] SUB_CFG         = 3'h0;
  localparam logic [2:0] SUB_LOW         = 3'h1;
  localparam logic [2:0] SUB_HIGH        = 3'h2;
  localparam logic [2:0] SUB_DELAY       = 3'h3;
  localparam logic [2:0] SUB_PULSE       = 3'h4;
  localparam logic [2:0] SUB_COUNTS      = 3'h5;

  // Field positions
  localparam int CTRL_SIM_BIT   = 0;
  localparam int CTRL_PROG_BIT  = 1;
  localparam int CTRL_SPEED_BIT = 2;
  localparam int CTRL_SEL_LSB   = 4;
  localparam int CFG_FUNC_LSB   = 0;
  localparam int CFG_EN_BIT     = 2;
  localparam int CFG_NC_BIT     = 3;

  // Parameter selection walks 0..PARAM_LAST
  localparam logic [4:0] PARAM_LAST = 5'h11;

  // Reset values of relay settings
  localparam logic [15:0] RST_LOW    = 16'h0000;
  localparam logic [15:0] RST_HIGH   = 16'hffff;
  localparam logic [6:0]  RST_DELAY  = 7'h00;
  localparam logic [7:0]  RST_PULSE  = 8'h0a;
  localparam logic [19:0] RST_COUNTS = 20'h00001;

  typedef enum logic [1:0] {
    FN_TOTAL_PULSE_REPEAT,
    FN_UNDER_FLOW_ALARM,
    FN_OVER_FLOW_ALARM,
    FN_WINDOW_FLOW_ALARM
  } rap_func_t;

  typedef struct packed {
    rap_func_t   func;
    logic        enable;
    logic        normally_closed;
    logic [15:0] low_sp;
    logic [15:0] high_sp;
    logic [6:0]  delay_s;
    logic [7:0]  pulse_hund;
    logic [19:0] counts_per_pulse;
  } rap_relay_cfg_t;

  typedef struct packed {
    logic [5:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rap_bus_req_t;

endpackage

// ### hdl/rap_relay.sv
// One relay channel: pulse repeater or rate alarm with operate delay.
// Assumes rate, tick and count_tick come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module rap_relay
  import rap_pkg::*;
(
  input  wire logic           clk,        // System clock
  input  wire logic           rst_b,      // Async reset, active low
  input  wire rap_relay_cfg_t cfg,        // Channel settings
  input  wire logic [15:0]    rate,       // Scaled rate
  input  wire logic           tick,       // 10 ms enable
  input  wire logic           count_tick, // One total count
  output logic                contact_q   // Contact closed
);

  typedef struct packed {
    logic [13:0] dly;
    logic        alarm;
    logic [19:0] cnt;
    logic [3:0]  pend;
    logic        act;
    logic [7:0]  ptim;
    logic        contact;
  } rap_rly_st_t;

  rap_rly_st_t s_q;
  rap_rly_st_t s_d;
  logic        cond;
  logic        due;
  logic        active;

  always_comb begin
    s_d = s_q;
    case (cfg.func) // R9
      FN_UNDER_FLOW_ALARM:  cond = rate < cfg.low_sp; // R14 R17
      FN_OVER_FLOW_ALARM:   cond = rate > cfg.high_sp; // R15 R18
      FN_WINDOW_FLOW_ALARM: cond = (rate < cfg.low_sp) || (rate > cfg.high_sp); // R16
      default:              cond = 1'b0;
    endcase
    if (!cfg.enable || !cond) begin
      s_d.dly   = 14'h0000; // R22
      s_d.alarm = 1'b0; // R22
    end else if (s_q.dly >= 14'(cfg.delay_s * TICKS_PER_S)) begin
      s_d.alarm = 1'b1; // R20 R21
    end else if (tick) begin
      s_d.dly = s_q.dly + 14'h0001; // R20
    end
    due = count_tick && ((s_q.cnt + 20'h00001) >= cfg.counts_per_pulse); // R13
    if (!cfg.enable || cfg.func != FN_TOTAL_PULSE_REPEAT) begin
      s_d.cnt  = 20'h00000;
      s_d.pend = 4'h0;
      s_d.act  = 1'b0;
      s_d.ptim = 8'h00;
    end else begin
      if (count_tick) begin
        s_d.cnt = due ? 20'h00000 : s_q.cnt + 20'h00001; // R13
      end
      // Saturates rather than wraps if pulses outrun the contact
      if (due && s_q.pend != 4'hf) begin
        s_d.pend = s_q.pend + 4'h1; // R23
      end
      if (s_q.act) begin
        if (tick) begin
          if ((s_q.ptim + 8'h01) >= cfg.pulse_hund) begin
            s_d.act = 1'b0; // R12
          end else begin
            s_d.ptim = s_q.ptim + 8'h01; // R12
          end
        end
      end else if (s_d.pend != 4'h0) begin
        s_d.act  = 1'b1; // R11 R23
        s_d.ptim = 8'h00;
        s_d.pend = s_d.pend - 4'h1; // R23
      end
    end
    active    = (cfg.func == FN_TOTAL_PULSE_REPEAT) ? s_q.act : s_q.alarm;
    s_d.contact = (active & cfg.enable) ^ cfg.normally_closed; // R10 R11
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign contact_q = s_q.contact;

endmodule
`default_nettype wire

// ### hdl/rap_top.sv
// Relay, alarm and pulse output controller with push-button programming.
// Assumes the function button is an unsynchronised pin; rate, speed and
// count ticks come from logic on clk. Settings live in the external
// nonvolatile store, which captures them on nv_commit_q and is reloaded
// by software over the register port once a button hold has entered programming.
//
// Summary of operation
// (R1) Five-second button hold enters programming; another five-second hold leaves it.
// (R2) Leaving programming switches simulation off.
// (R3) Rate span edited under simulation is temporary; stored span returns afterwards.
// (R4) Short press in programming steps to the next parameter.
// (R5) Short press in running switches the display to belt speed.
// (R6) Speed span multiplies measured belt speed for the displayed speed.
// (R7) Pulse train frequency follows rate times a separate pulse span.
// (R8) Two relays with independent function, polarity and settings.
// (R9) Function choices: pulse repeater, under, over and window flow alarm.
// (R10) A relay follows its function only while enabled.
// (R11) Repeater closes for pulse duration when count is reached; closed polarity inverts.
// (R12) Pulse duration is in hundredths of a second.
// (R13) Scale factor sets total counts between repeater pulses.
// (R14) Under flow alarm changes contact when rate drops below low setpoint.
// (R15) Over flow alarm changes contact when rate exceeds high setpoint.
// (R16) Window alarm changes contact below low or above high setpoint.
// (R17) Each relay holds a four-digit low setpoint in displayed units.
// (R18) Each relay holds a four-digit high setpoint in displayed units.
// (R19) Operator re-enters setpoints after changing rate units; no rescaling.
// (R20) Alarm switches only after its condition persists for delay seconds.
// (R21) Delay zero switches the alarm at once.
// (R22) Clearing condition restarts the delay and returns the contact to idle.
// (R23) A pulse due during an active pulse is held and issued afterwards.
// (R24) Settings are kept across power cycles in nonvolatile storage.
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rap_top
  import rap_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC // Cycles per 10 ms tick
)
(
  input  wire logic         clk,            // 10 MHz clock
  input  wire logic         rst_b,          // Async reset, active low
  input  wire logic         func_btn,       // Function button pin, high pressed
  input  wire logic [15:0]  rate_in,        // Measured rate
  input  wire logic [15:0]  speed_in,       // Measured belt speed
  input  wire logic         count_tick,     // One total count, pulse
  input  wire rap_bus_req_t bus_req,        // Register request
  output logic [31:0]       rdata_q,        // Read data, cycle after rd
  output logic [1:0]        relay_closed_q, // Relay contacts closed
  output logic              hfr_q,          // Rate pulse train
  output logic              disp_speed_q,   // Display shows speed
  output logic              prog_q,         // Programming state
  output logic              sim_q,          // Simulation on
  output logic [4:0]        param_sel_q,    // Selected parameter
  output logic [15:0]       rate_disp_q,    // Scaled rate
  output logic [15:0]       speed_disp_q,   // Scaled speed
  output logic              nv_commit_q     // Capture settings, pulse
);

  typedef struct packed {
    logic [16:0]          div;
    logic                 tick;
    logic [1:0]           btn_sync;
    logic                 btn_prev;
    logic [9:0]           hold;
    logic                 held;
    logic                 prog;
    logic                 sim;
    logic                 disp_speed;
    logic [4:0]           sel;
    logic [15:0]          rate_span;
    logic [15:0]          rate_tmp;
    logic [15:0]          speed_span;
    logic [15:0]          hfr_span;
    logic [15:0]          rate_disp;
    logic [15:0]          speed_disp;
    logic [23:0]          hfr_acc;
    logic                 hfr;
    logic                 nv_commit;
    logic [31:0]          rdata;
    rap_relay_cfg_t [1:0] rcfg;
  } rap_top_st_t;

  localparam rap_relay_cfg_t RCFG_RST = '{
    func:             FN_TOTAL_PULSE_REPEAT,
    enable:           1'b0,
    normally_closed:  1'b0,
    low_sp:           RST_LOW,
    high_sp:          RST_HIGH,
    delay_s:          RST_DELAY,
    pulse_hund:       RST_PULSE,
    counts_per_pulse: RST_COUNTS
  };

  rap_top_st_t s_q;
  rap_top_st_t s_d;

  logic [15:0] eff_span;
  logic [31:0] rate_prod;
  logic [31:0] speed_prod;
  logic [31:0] hfr_prod;
  logic [24:0] hfr_sum;
  logic        btn;
  logic        rly_hit;
  logic        rly_idx;
  logic [2:0]  rly_sub;

  always_comb begin
    s_d = s_q;
    s_d.nv_commit = 1'b0;
    s_d.rdata     = 32'h00000000;

    // 10 ms enable
    s_d.tick = 1'b0;
    if (s_q.div >= 17'(TICK_CYCLES - 1)) begin
      s_d.div  = 17'h00000;
      s_d.tick = 1'b1;
    end else begin
      s_d.div = s_q.div + 17'h00001;
    end

    // Button: only the second stage is read by logic
    s_d.btn_sync = {s_q.btn_sync[0], func_btn};
    btn          = s_q.btn_sync[1];
    s_d.btn_prev = btn;
    if (btn && !s_q.held && s_q.tick) begin
      if (s_q.hold >= 10'(HOLD_TICKS - 1)) begin
        s_d.held = 1'b1;
        s_d.prog = !s_q.prog; // R1
        if (s_q.prog) begin
          s_d.sim       = 1'b0; // R2 R3
          s_d.nv_commit = 1'b1; // R24
        end
      end else begin
        s_d.hold = s_q.hold + 10'h001; // R1
      end
    end
    if (s_q.btn_prev && !btn) begin
      // A long hold ends without counting as a short press
      if (!s_q.held) begin
        if (s_q.prog) begin
          s_d.sel = (s_q.sel >= PARAM_LAST) ? 5'h00 : s_q.sel + 5'h01; // R4
        end else begin
          s_d.disp_speed = !s_q.disp_speed; // R5
        end
      end
      s_d.hold = 10'h000;
      s_d.held = 1'b0;
    end

    // Scaling pipelines, one cycle each
    s_d.rate_disp  = rate_prod[SPAN_SHIFT +: 16];
    s_d.speed_disp = speed_prod[SPAN_SHIFT +: 16]; // R6
    s_d.hfr_acc    = hfr_sum[23:0]; // R7
    if (hfr_sum[24]) begin
      s_d.hfr = !s_q.hfr; // R7
    end

    // Settings change only in programming; the exit cycle drops writes so sim stays off
    if (bus_req.wr && s_q.prog && s_d.prog) begin // R2
      if (rly_hit) begin
        case (rly_sub)
          SUB_CFG: begin
            s_d.rcfg[rly_idx].func            = rap_func_t'(bus_req.wdata[CFG_FUNC_LSB +: 2]); // R9
            s_d.rcfg[rly_idx].enable          = bus_req.wdata[CFG_EN_BIT]; // R10
            s_d.rcfg[rly_idx].normally_closed = bus_req.wdata[CFG_NC_BIT];
          end
          SUB_LOW: begin
            s_d.rcfg[rly_idx].low_sp = bus_req.wdata[15:0]; // R17
          end
          SUB_HIGH: begin
            s_d.rcfg[rly_idx].high_sp = bus_req.wdata[15:0]; // R18
          end
          SUB_DELAY: begin
            s_d.rcfg[rly_idx].delay_s = bus_req.wdata[6:0];
          end
          SUB_PULSE: begin
            s_d.rcfg[rly_idx].pulse_hund = bus_req.wdata[7:0];
          end
          SUB_COUNTS: begin
            s_d.rcfg[rly_idx].counts_per_pulse = bus_req.wdata[19:0];
          end
          default: begin
          end
        endcase
      end else begin
        case (bus_req.addr)
          ADDR_CTRL: begin
            s_d.sim = bus_req.wdata[CTRL_SIM_BIT];
            if (bus_req.wdata[CTRL_SIM_BIT] && !s_q.sim) begin
              s_d.rate_tmp = s_q.rate_span; // R3
            end
          end
          ADDR_RATE_SPAN: begin
            if (s_q.sim) begin
              s_d.rate_tmp = bus_req.wdata[15:0]; // R3
            end else begin
              s_d.rate_span = bus_req.wdata[15:0];
            end
          end
          ADDR_SPEED_SPAN: begin
            s_d.speed_span = bus_req.wdata[15:0]; // R6
          end
          ADDR_HFR_SPAN: begin
            s_d.hfr_span = bus_req.wdata[15:0]; // R7
          end
          default: begin
          end
        endcase
      end
    end

    if (bus_req.rd) begin
      if (rly_hit) begin
        case (rly_sub)
          SUB_CFG: begin
            s_d.rdata[CFG_FUNC_LSB +: 2] = s_q.rcfg[rly_idx].func;
            s_d.rdata[CFG_EN_BIT]        = s_q.rcfg[rly_idx].enable;
            s_d.rdata[CFG_NC_BIT]        = s_q.rcfg[rly_idx].normally_closed;
          end
          SUB_LOW: begin
            s_d.rdata[15:0] = s_q.rcfg[rly_idx].low_sp;
          end
          SUB_HIGH: begin
            s_d.rdata[15:0] = s_q.rcfg[rly_idx].high_sp;
          end
          SUB_DELAY: begin
            s_d.rdata[6:0] = s_q.rcfg[rly_idx].delay_s;
          end
          SUB_PULSE: begin
            s_d.rdata[7:0] = s_q.rcfg[rly_idx].pulse_hund;
          end
          SUB_COUNTS: begin
            s_d.rdata[19:0] = s_q.rcfg[rly_idx].counts_per_pulse;
          end
          default: begin
          end
        endcase
      end else begin
        case (bus_req.addr)
          ADDR_CTRL: begin
            s_d.rdata[CTRL_SIM_BIT]      = s_q.sim;
            s_d.rdata[CTRL_PROG_BIT]     = s_q.prog;
            s_d.rdata[CTRL_SPEED_BIT]    = s_q.disp_speed;
            s_d.rdata[CTRL_SEL_LSB +: 5] = s_q.sel;
          end
          ADDR_RATE_SPAN: begin
            s_d.rdata[15:0] = eff_span;
          end
          ADDR_SPEED_SPAN: begin
            s_d.rdata[15:0] = s_q.speed_span;
          end
          ADDR_HFR_SPAN: begin
            s_d.rdata[15:0] = s_q.hfr_span;
          end
          ADDR_RATE_DISP: begin
            s_d.rdata[15:0] = s_q.rate_disp;
          end
          ADDR_SPEED_DISP: begin
            s_d.rdata[15:0] = s_q.speed_disp;
          end
          ADDR_RELAY_ST: begin
            s_d.rdata[1:0] = relay_closed_q;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Simulation span shadows the stored one and is simply dropped on exit
  assign eff_span   = s_q.sim ? s_q.rate_tmp : s_q.rate_span; // R3
  assign rate_prod  = rate_in * eff_span;
  assign speed_prod = speed_in * s_q.speed_span; // R6
  // Full 32-bit product; bits 31:8 of it are added to the accumulator each cycle
  assign hfr_prod   = s_q.rate_disp * s_q.hfr_span; // R7
  assign hfr_sum    = {1'b0, s_q.hfr_acc} + {1'b0, hfr_prod[HFR_SHIFT +: 24]};
  assign rly_hit    = bus_req.addr[5:4] == RELAY_PAGE;
  assign rly_idx    = bus_req.addr[3];
  assign rly_sub    = bus_req.addr[2:0];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q            <= '0;
      s_q.rate_span  <= SPAN_UNITY;
      s_q.rate_tmp   <= SPAN_UNITY;
      s_q.speed_span <= SPAN_UNITY;
      s_q.hfr_span   <= SPAN_UNITY;
      s_q.rcfg       <= {RCFG_RST, RCFG_RST};
    end else begin
      s_q <= s_d;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_relay
    rap_relay u_relay ( // R8
      .clk        (clk),
      .rst_b      (rst_b),
      .cfg        (s_q.rcfg[g]),
      .rate       (s_q.rate_disp),
      .tick       (s_q.tick),
      .count_tick (count_tick),
      .contact_q  (relay_closed_q[g])
    );
  end

  assign rdata_q      = s_q.rdata;
  assign hfr_q        = s_q.hfr;
  assign disp_speed_q = s_q.disp_speed;
  assign prog_q       = s_q.prog;
  assign sim_q        = s_q.sim;
  assign param_sel_q  = s_q.sel;
  assign rate_disp_q  = s_q.rate_disp;
  assign speed_disp_q = s_q.speed_disp;
  assign nv_commit_q  = s_q.nv_commit;

endmodule
`default_nettype wire

// ### verification/rap_checker.sv
// Port-level assertions for the relay, alarm and pulse controller.
// Assumes it is bound onto rap_top; every port sits on clk.
`timescale 1ns/1ps
`default_nettype none
module rap_checker
  import rap_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  input wire logic         clk,            // Clock
  input wire logic         rst_b,          // Reset, active low
  input wire logic         func_btn,       // Button pin
  input wire logic [15:0]  rate_in,        // Rate
  input wire logic [15:0]  speed_in,       // Speed
  input wire logic         count_tick,     // Total count
  input wire rap_bus_req_t bus_req,        // Register request
  input wire logic [31:0]  rdata_q,        // Read data
  input wire logic [1:0]   relay_closed_q, // Contacts
  input wire logic         hfr_q,          // Pulse train
  input wire logic         disp_speed_q,   // Speed display
  input wire logic         prog_q,         // Programming
  input wire logic         sim_q,          // Simulation
  input wire logic [4:0]   param_sel_q,    // Selection
  input wire logic [15:0]  rate_disp_q,    // Scaled rate
  input wire logic [15:0]  speed_disp_q,   // Scaled speed
  input wire logic         nv_commit_q     // Commit pulse
);
  // Raw pin is counted, so sync delay only makes the real hold longer
  localparam int MIN_HOLD = 499 * TICK_CYCLES;
  logic [31:0] btn_cyc_q;
  logic [31:0] btn_cyc_d;
  always_comb btn_cyc_d = func_btn ? btn_cyc_q + 32'h1 : 32'h0;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) btn_cyc_q <= 32'h0;
    else btn_cyc_q <= btn_cyc_d;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_hold_toggle: assert property ($changed(prog_q) |-> btn_cyc_q >= MIN_HOLD)
    else $error("Programming state changed without a full hold");
  a_leave_sim_off: assert property ($fell(prog_q) |-> !sim_q)
    else $error("Simulation still on after leaving programming");
  a_sim_in_prog: assert property (sim_q |-> prog_q)
    else $error("Simulation on outside programming");
  a_commit_leave: assert property (nv_commit_q == $fell(prog_q))
    else $error("Commit pulse not tied to leaving programming");
  a_sel_step: assert property (prog_q && $past(prog_q) && $changed(param_sel_q) |->
    param_sel_q == (($past(param_sel_q) == PARAM_LAST) ? 5'h00 : $past(param_sel_q) + 5'h01))
    else $error("Selection did not step to the next parameter");
  a_speed_run_only: assert property ($changed(disp_speed_q) |-> !prog_q && !$past(prog_q))
    else $error("Speed display changed while programming");
  a_read_idle: assert property (!$past(bus_req.rd) |-> rdata_q == 32'h0)
    else $error("Read data not zero outside read answer");
  a_hfr_quiet: assert property ($past(rate_disp_q) == 16'h0 && $past(rate_disp_q, 2) == 16'h0 &&
    $past(rate_disp_q, 3) == 16'h0 |-> $stable(hfr_q))
    else $error("Pulse train moved at zero rate");
  c_enter: cover property ($rose(prog_q));
  c_leave: cover property ($fell(prog_q));
  c_relay_close: cover property ($rose(relay_closed_q[0]));
endmodule
`default_nettype wire

// ### verification/rap_panel.sv
// Operator panel and field side: button, contacts, remote rate indicator.
// Assumes the bench calls hold_btn and reads the counters by hierarchy.
`timescale 1ns/1ps
`default_nettype none
module rap_panel (
  input  wire logic       clk,            // Clock
  input  wire logic [1:0] relay_closed_q, // Contacts closed
  input  wire logic       hfr_q,          // Pulse train
  output logic            func_btn        // Button, high pressed
);
  int   closed_cyc [2] = '{0, 0};
  int   hfr_edges      = 0;
  logic hfr_seen       = 1'b0;
  initial func_btn = 1'b0;
  // No bounce modelled; the release is left time to pass the synchroniser
  task automatic hold_btn(input int cyc);
    @(posedge clk) func_btn <= 1'b1;
    repeat (cyc) @(posedge clk);
    func_btn <= 1'b0;
    repeat (40) @(posedge clk);
  endtask
  always @(posedge clk) begin
    hfr_seen <= hfr_q;
    if (hfr_q !== hfr_seen) hfr_edges <= hfr_edges + 1;
    for (int g = 0; g < 2; g++) begin
      if (relay_closed_q[g]) closed_cyc[g] <= closed_cyc[g] + 1;
    end
  end
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the relay, alarm and pulse controller.
// Assumes a ten-cycle tick and the panel model pressing the button.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rap_pkg::*;
  localparam int TK   = 10;
  localparam int LONG = HOLD_TICKS * TK + 100;
  logic         clk        = 1'b0;
  logic         rst_b      = 1'b0;
  logic [15:0]  rate_in    = 16'h0;
  logic [15:0]  speed_in   = 16'h0;
  logic         count_tick = 1'b0;
  rap_bus_req_t bus_req    = '0;
  logic         func_btn;
  logic [31:0]  rdata_q;
  logic [1:0]   relay_closed_q;
  logic         hfr_q, disp_speed_q, prog_q, sim_q, nv_commit_q;
  logic [4:0]   param_sel_q, sel0;
  logic [15:0]  rate_disp_q, speed_disp_q;
  int           mismatches = 0;
  int           compares   = 0;
  int           n;
  always #50 clk = ~clk;
  rap_top #(.TICK_CYCLES(TK)) dut_u (.clk, .rst_b, .func_btn, .rate_in, .speed_in, .count_tick,
    .bus_req, .rdata_q, .relay_closed_q, .hfr_q, .disp_speed_q, .prog_q, .sim_q, .param_sel_q,
    .rate_disp_q, .speed_disp_q, .nv_commit_q);
  rap_panel panel_u (.clk, .relay_closed_q, .hfr_q, .func_btn);
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_near(input int got, input int exp, input int tol);
    compares++;
    if (got < exp - tol || got > exp + tol) begin
      mismatches++;
      $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk) bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    @(posedge clk) bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus_req.rd <= 1'b0;
    @(negedge clk) chk(rdata_q, e);
  endtask
  function automatic logic [5:0] ra(input logic g, input logic [2:0] s);
    return {RELAY_PAGE, g, s};
  endfunction
  task automatic set_alarm(input logic g, input logic [3:0] c, input logic [15:0] lo, hi,
                           input logic [6:0] d);
    wr(ra(g, SUB_CFG), {28'h0, c});
    wr(ra(g, SUB_LOW), {16'h0, lo});
    wr(ra(g, SUB_HIGH), {16'h0, hi});
    wr(ra(g, SUB_DELAY), {25'h0, d});
  endtask
  task automatic rate_chk(input logic [15:0] v, input int w, input logic [1:0] e);
    @(posedge clk) rate_in <= v;
    repeat (w) @(posedge clk);
    @(negedge clk) chk(relay_closed_q, e);
  endtask
  task automatic ticks(input int k);
    repeat (k) @(posedge clk) count_tick <= 1'b1;
    @(posedge clk) count_tick <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(ADDR_RATE_SPAN, {16'h0, SPAN_UNITY});
    rd(ra(1'b0, SUB_HIGH), {16'h0, RST_HIGH});
    rd(ra(1'b1, SUB_PULSE), {24'h0, RST_PULSE});
    rd(ra(1'b1, SUB_COUNTS), {12'h0, RST_COUNTS});
    rd(6'h3f, 32'h0);
    wr(ADDR_RATE_SPAN, 32'h800);
    rd(ADDR_RATE_SPAN, {16'h0, SPAN_UNITY});
    panel_u.hold_btn(50);
    chk(disp_speed_q, 1'b1);
    panel_u.hold_btn(50);
    chk(disp_speed_q, 1'b0);
    panel_u.hold_btn(LONG);
    chk(prog_q, 1'b1);
    sel0 = param_sel_q;
    panel_u.hold_btn(50);
    chk(param_sel_q, (sel0 == PARAM_LAST) ? 5'h0 : sel0 + 5'h1);
    for (int i = 0; i < 17; i++) panel_u.hold_btn(50);
    chk(param_sel_q, sel0);
    wr(ADDR_CTRL, 32'h1);
    @(negedge clk) chk(sim_q, 1'b1);
    wr(ADDR_RATE_SPAN, 32'h800);
    wr(ADDR_SPEED_SPAN, 32'h800);
    wr(ADDR_HFR_SPAN, 32'hffff);
    @(posedge clk) begin
      rate_in  <= 16'd100;
      speed_in <= 16'd100;
    end
    rd(ADDR_RATE_SPAN, 32'h800);
    chk(rate_disp_q, 16'd200);
    chk(speed_disp_q, 16'd200);
    set_alarm(1'b0, {2'b01, FN_UNDER_FLOW_ALARM}, 16'd100, 16'hffff, 7'd0);
    set_alarm(1'b1, {2'b11, FN_OVER_FLOW_ALARM}, 16'd0, 16'd200, 7'd1);
    rd(ra(1'b0, SUB_LOW), 32'd100);
    rd(ra(1'b1, SUB_HIGH), 32'd200);
    panel_u.hold_btn(LONG);
    chk(prog_q, 1'b0);
    chk(sim_q, 1'b0);
    rd(ADDR_RATE_SPAN, {16'h0, SPAN_UNITY});
    chk(rate_disp_q, 16'd100);
    rate_chk(16'd100, 5, 2'b10);
    rate_chk(16'd99, 5, 2'b11);
    rate_chk(16'd150, 5, 2'b10);
    rate_chk(16'd300, 500, 2'b10);
    rate_chk(16'd150, 5, 2'b10);
    rate_chk(16'd201, 900, 2'b10);
    rate_chk(16'd201, 150, 2'b00);
    // Window of 10000 cycles; the tolerance of one absorbs the partial carry count
    for (int k = 1; k <= 2; k++) begin
      @(posedge clk) rate_in <= 16'(1024 * k);
      repeat (4) @(posedge clk);
      n = panel_u.hfr_edges;
      repeat (10000) @(posedge clk);
      chk_near(panel_u.hfr_edges - n, int'((longint'(10000) * ((1024 * k * 65535) >> 8)) >> 24), 1);
    end
    @(posedge clk) rate_in <= 16'd150;
    panel_u.hold_btn(LONG);
    rate_chk(16'd50, 5, 2'b11);
    wr(ra(1'b0, SUB_CFG), 32'h1);
    rd(ADDR_RELAY_ST, 32'h2);
    // Setpoints entered again by the operator; stored ones are never rescaled
    set_alarm(1'b1, {2'b01, FN_WINDOW_FLOW_ALARM}, 16'd100, 16'd200, 7'd0);
    set_alarm(1'b0, {2'b01, FN_TOTAL_PULSE_REPEAT}, 16'd0, 16'hffff, 7'd0);
    wr(ra(1'b0, SUB_PULSE), 32'd20);
    wr(ra(1'b0, SUB_COUNTS), 32'd3);
    panel_u.hold_btn(LONG);
    rate_chk(16'd50, 5, 2'b10);
    rate_chk(16'd150, 5, 2'b00);
    rate_chk(16'd300, 5, 2'b10);
    rate_chk(16'd150, 5, 2'b00);
    ticks(2);
    repeat (5) @(posedge clk);
    @(negedge clk) chk(relay_closed_q, 2'b00);
    ticks(1);
    repeat (150) @(posedge clk);
    @(negedge clk) chk(relay_closed_q, 2'b01);
    repeat (100) @(posedge clk);
    @(negedge clk) chk(relay_closed_q, 2'b00);
    n = panel_u.closed_cyc[0];
    ticks(6);
    repeat (600) @(posedge clk);
    chk_near(panel_u.closed_cyc[0] - n, 400, 25);
    stop_test;
  end
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    stop_test;
  end
endmodule
bind rap_top rap_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk, .rst_b, .func_btn, .rate_in,
  .speed_in, .count_tick, .bus_req, .rdata_q, .relay_closed_q, .hfr_q, .disp_speed_q, .prog_q,
  .sim_q, .param_sel_q, .rate_disp_q, .speed_disp_q, .nv_commit_q);
`default_nettype wire
